// >>> hw/lleu_map.vh
`ifndef LLEU_MAP_VH
`define LLEU_MAP_VH
// ----------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------
`define LLEU_OP_CONTACT 5'h00
`define LLEU_OP_CMP 5'h01
`define LLEU_OP_ANB 5'h02
`define LLEU_OP_ORB 5'h03
`define LLEU_OP_PUSH 5'h04
`define LLEU_OP_PEEK 5'h05
`define LLEU_OP_POP 5'h06
`define LLEU_OP_NEG 5'h07
`define LLEU_OP_RPULSE 5'h08
`define LLEU_OP_FPULSE 5'h09
`define LLEU_OP_REDGE 5'h0A
`define LLEU_OP_FEDGE 5'h0B
`define LLEU_OP_OUT 5'h0C
`define LLEU_OP_SET 5'h0D
`define LLEU_OP_RST 5'h0E
`define LLEU_OP_PLS 5'h0F
`define LLEU_OP_PLF 5'h10
`define LLEU_OP_SFT 5'h11
`define LLEU_OP_MAIN_PROGRAM_FINISH 5'h12
`define LLEU_OP_END 5'h13
`define LLEU_OP_STOP 5'h14
`define LLEU_OP_ADD 5'h15
`define LLEU_OP_SUB 5'h16
`define LLEU_OP_MUL 5'h17
`define LLEU_OP_DIV 5'h18
`define LLEU_OP_BADD 5'h19
`define LLEU_OP_BSUB 5'h1A
`define LLEU_OP_BMUL 5'h1B
`define LLEU_OP_BDIV 5'h1C
`define LLEU_OP_BLOCK_WORD_COMPARE 5'h1D
`define LLEU_OP_BKADD 5'h1E
`define LLEU_OP_BKSUB 5'h1F
// ----------------------------------------------------------------
// combine modes, contact kinds, relations
// ----------------------------------------------------------------
`define LLEU_MODE_LOAD 2'h0
`define LLEU_MODE_SERIES 2'h1
`define LLEU_MODE_PARALLEL 2'h2
`define LLEU_KIND_LEVEL 2'h0
`define LLEU_KIND_INV 2'h1
`define LLEU_KIND_RISE 2'h2
`define LLEU_KIND_FALL 2'h3
`define LLEU_REL_EQ 3'h0
`define LLEU_REL_NE 3'h1
`define LLEU_REL_GT 3'h2
`define LLEU_REL_LE 3'h3
`define LLEU_REL_LT 3'h4
`define LLEU_REL_GE 3'h5
// ----------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------
`define LLEU_STACK_DEPTH 16
`define LLEU_EDGE_BITS 16
`define LLEU_WORDS_ONE 3'h1
`define LLEU_WORDS_TWO 3'h2
`define LLEU_WORDS_FOUR 3'h4
`endif

// >>> hw/lleu_exec_unit.v
// Overview of operation
// - load starts result from bit or complement
// - series contact ANDs result with bit
// - parallel contact ORs result with bit
// - edge contacts true only in edge scan
// - block combine ANDs or ORs two blocks
// - result stack: push, peek, pop
// - negate complements operation result
// - result pulses true on result edge only
// - edge bit pulses keep state in storage
// - one-scan pulse on condition edge, then off
// - bit shift moves device one position
// - finish ends main; end ends scan
// - halt stops until run given again
// - signed 16-bit six-relation comparison contacts
// - same six relations on 32-bit pairs
// - block compare writes consecutive bit results
// - add/subtract in place or three-operand
// - multiply stores double-length product, low first
// - divide writes quotient then remainder
// - BCD add, subtract, multiply, divide
// - block add/subtract into consecutive words
`timescale 1ns/10ps
`include "lleu_map.vh"
`default_nettype none
module lleu_exec_unit #(
  parameter STACK_DEPTH = `LLEU_STACK_DEPTH,
  parameter EDGE_BITS = `LLEU_EDGE_BITS,
  parameter EIDX_W = 4,
  parameter CNT_W = 16
) (
  input wire clk,
  input wire rstn,
  input wire instr_valid,
  input wire [4:0] instr_op,
  input wire [1:0] instr_mode,
  input wire [1:0] instr_kind,
  input wire [2:0] instr_rel,
  input wire instr_wide,
  input wire instr_three,
  input wire instr_pulse,
  input wire [EIDX_W-1:0] edge_idx,
  input wire [CNT_W-1:0] blk_count,
  input wire bit_in,
  input wire bit_prev,
  input wire [31:0] src1,
  input wire [31:0] src2,
  input wire [31:0] dst_in,
  input wire run_cmd,
  output reg result,
  output reg busy,
  output reg halted,
  output reg [CNT_W-1:0] elem_idx,
  output reg wr_en,
  output reg [63:0] wr_data,
  output reg [2:0] wr_words,
  output reg [CNT_W-1:0] wr_offset,
  output reg bit_wr_en,
  output reg bit_wr_val,
  output reg [CNT_W-1:0] bit_wr_offset,
  output reg shift_clr,
  output reg main_done,
  output reg scan_done,
  output reg div_err
);
  localparam ST_IDLE = 1'b0;
  localparam ST_BLOCK = 1'b1;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // signed relation of two 32-bit values
  function rel_ok;
    input [2:0] rel;
    input [31:0] a;
    input [31:0] b;
    begin
      case (rel)
        `LLEU_REL_EQ: rel_ok = (a == b);
        `LLEU_REL_NE: rel_ok = (a != b);
        `LLEU_REL_GT: rel_ok = ($signed(a) > $signed(b));
        `LLEU_REL_LE: rel_ok = ($signed(a) <= $signed(b));
        `LLEU_REL_LT: rel_ok = ($signed(a) < $signed(b));
        `LLEU_REL_GE: rel_ok = ($signed(a) >= $signed(b));
        default: rel_ok = 1'b0;
      endcase
    end
  endfunction

  // merge a contact value into the result by mode
  function combine;
    input [1:0] mode;
    input res;
    input v;
    begin
      case (mode)
        `LLEU_MODE_SERIES: combine = res & v;
        `LLEU_MODE_PARALLEL: combine = res | v;
        default: combine = v;
      endcase
    end
  endfunction

  // digit-serial BCD add or subtract, wraps modulo 10^8
  function [31:0] bcd_addsub;
    input [31:0] a;
    input [31:0] b;
    input sub;
    integer i;
    reg [4:0] d;
    reg c;
    begin
      c = sub;
      bcd_addsub = 32'h0;
      for (i = 0; i < 8; i = i + 1) begin
        d = {1'b0, a[i*4 +: 4]} + c;
        d = sub ? d + 5'h9 - {1'b0, b[i*4 +: 4]} : d + {1'b0, b[i*4 +: 4]};
        c = (d > 5'h9);
        if (c) begin
          d = d - 5'hA;
        end
        bcd_addsub[i*4 +: 4] = d[3:0];
      end
    end
  endfunction

  // eight BCD digits to binary
  function [31:0] bcd2bin;
    input [31:0] v;
    integer i;
    begin
      bcd2bin = 32'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        bcd2bin = bcd2bin * 32'hA + {28'h0, v[i*4 +: 4]};
      end
    end
  endfunction

  // binary to sixteen BCD digits by shift-and-add-three
  function [63:0] bin2bcd;
    input [63:0] v;
    integer i;
    integer j;
    begin
      bin2bcd = 64'h0;
      for (i = 63; i >= 0; i = i - 1) begin
        for (j = 0; j < 16; j = j + 1) begin
          if (bin2bcd[j*4 +: 4] > 4'h4) begin
            bin2bcd[j*4 +: 4] = bin2bcd[j*4 +: 4] + 4'h3;
          end
        end
        bin2bcd = {bin2bcd[62:0], v[i]};
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg rst_q1;
  reg rst_q2;
  // release through two flops so no control flop leaves reset on a raw edge
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  // ----------------------------------------------------------------
  // operand preparation
  // ----------------------------------------------------------------
  reg [STACK_DEPTH-1:0] res_stk;
  reg [STACK_DEPTH-1:0] blk_stk;
  reg [EDGE_BITS-1:0] edge_mem;
  reg run_q;
  reg [CNT_W-1:0] blk_left;
  reg blk_sub;
  reg blk_cmp;
  reg [2:0] blk_rel;
  wire take = instr_valid & ~busy & ~halted;
  wire edge_old = edge_mem[edge_idx];
  // in-place form uses the destination as first operand
  wire [31:0] opa = instr_three ? src1 : dst_in;
  wire [31:0] opb = instr_three ? src2 : src1;
  wire [31:0] a32 = instr_wide ? opa : {{16{opa[15]}}, opa[15:0]};
  wire [31:0] b32 = instr_wide ? opb : {{16{opb[15]}}, opb[15:0]};
  wire [31:0] c1 = instr_wide ? src1 : {{16{src1[15]}}, src1[15:0]};
  wire [31:0] c2 = instr_wide ? src2 : {{16{src2[15]}}, src2[15:0]};
  wire [31:0] ba = instr_wide ? opa : {16'h0, opa[15:0]};
  wire [31:0] bb = instr_wide ? opb : {16'h0, opb[15:0]};
  wire [31:0] bina = bcd2bin(ba);
  wire [31:0] binb = bcd2bin(bb);
  wire signed [63:0] prod = $signed(a32) * $signed(b32);
  wire [63:0] bprod = bin2bcd({32'h0, bina} * {32'h0, binb});
  wire [31:0] quo = (b32 == 32'h0) ? 32'sh0 : $signed(a32) / $signed(b32);
  wire [31:0] rmd = (b32 == 32'h0) ? 32'sh0 : $signed(a32) % $signed(b32);
  wire [31:0] bq = (binb == 32'h0) ? 32'h0 : bina / binb;
  wire [31:0] br = (binb == 32'h0) ? 32'h0 : bina % binb;
  wire [63:0] bqd = bin2bcd({32'h0, bq});
  wire [63:0] brd = bin2bcd({32'h0, br});
  wire [31:0] bsum = bcd_addsub(ba, bb, 1'b0);
  wire [31:0] bdif = bcd_addsub(ba, bb, 1'b1);
  wire [31:0] kw = {{16{src1[15]}}, src1[15:0]};
  wire [31:0] lw = {{16{src2[15]}}, src2[15:0]};
  reg cval;

  // contact value before combining
  always @* begin
    case (instr_kind)
      `LLEU_KIND_INV: cval = ~bit_in;
      `LLEU_KIND_RISE: cval = bit_in & ~bit_prev;
      `LLEU_KIND_FALL: cval = ~bit_in & bit_prev;
      default: cval = bit_in;
    endcase
  end

  // ----------------------------------------------------------------
  // arithmetic result selection
  // ----------------------------------------------------------------
  reg [63:0] next_wr_data;
  reg [2:0] next_wr_words;
  reg is_arith;
  wire [2:0] w12 = instr_wide ? `LLEU_WORDS_TWO : `LLEU_WORDS_ONE;
  wire [2:0] w24 = instr_wide ? `LLEU_WORDS_FOUR : `LLEU_WORDS_TWO;
  // narrow products and divides are packed into two words, wide into four
  always @* begin
    next_wr_data = 64'h0;
    next_wr_words = w12;
    is_arith = 1'b1;
    case (instr_op)
      `LLEU_OP_ADD: next_wr_data = {32'h0, a32 + b32};
      `LLEU_OP_SUB: next_wr_data = {32'h0, a32 - b32};
      `LLEU_OP_MUL: begin
        next_wr_data = instr_wide ? prod : {32'h0, prod[31:0]};
        next_wr_words = w24;
      end
      `LLEU_OP_DIV: begin
        next_wr_data = instr_wide ? {rmd, quo} : {32'h0, rmd[15:0], quo[15:0]};
        next_wr_words = w24;
      end
      `LLEU_OP_BADD: next_wr_data = {32'h0, bsum};
      `LLEU_OP_BSUB: next_wr_data = {32'h0, bdif};
      `LLEU_OP_BMUL: begin
        next_wr_data = instr_wide ? bprod : {32'h0, bprod[31:0]};
        next_wr_words = w24;
      end
      `LLEU_OP_BDIV: begin
        next_wr_data = instr_wide ? {brd[31:0], bqd[31:0]} :
          {32'h0, brd[15:0], bqd[15:0]};
        next_wr_words = w24;
      end
      default: is_arith = 1'b0;
    endcase
    if (!instr_wide) begin
      if ((instr_op == `LLEU_OP_ADD) || (instr_op == `LLEU_OP_SUB) ||
          (instr_op == `LLEU_OP_BADD) || (instr_op == `LLEU_OP_BSUB)) begin
        next_wr_data[63:16] = 48'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  wire is_div = (instr_op == `LLEU_OP_DIV) | (instr_op == `LLEU_OP_BDIV);
  wire div_zero = (instr_op == `LLEU_OP_DIV) ? (b32 == 32'h0) : (binb == 32'h0);
  wire is_blk = (instr_op == `LLEU_OP_BLOCK_WORD_COMPARE) | (instr_op == `LLEU_OP_BKADD) |
    (instr_op == `LLEU_OP_BKSUB);
  // pulse-suffixed data ops fire only in the scan the result rises
  wire exec = result & (~instr_pulse | ~edge_old);
  wire [31:0] bk_sum = kw + lw;
  wire [31:0] bk_dif = kw - lw;

  // one process holds all control state; pulses default low each cycle
  always @(posedge clk or negedge rst_q2) begin
    if (!rst_q2) begin
      result <= 1'b0;
      busy <= ST_IDLE;
      halted <= 1'b0;
      elem_idx <= {CNT_W{1'b0}};
      wr_en <= 1'b0;
      wr_data <= 64'h0;
      wr_words <= `LLEU_WORDS_ONE;
      wr_offset <= {CNT_W{1'b0}};
      bit_wr_en <= 1'b0;
      bit_wr_val <= 1'b0;
      bit_wr_offset <= {CNT_W{1'b0}};
      shift_clr <= 1'b0;
      main_done <= 1'b0;
      scan_done <= 1'b0;
      div_err <= 1'b0;
      res_stk <= {STACK_DEPTH{1'b0}};
      blk_stk <= {STACK_DEPTH{1'b0}};
      edge_mem <= {EDGE_BITS{1'b0}};
      run_q <= 1'b0;
      blk_left <= {CNT_W{1'b0}};
      blk_sub <= 1'b0;
      blk_cmp <= 1'b0;
      blk_rel <= `LLEU_REL_EQ;
    end else begin
      wr_en <= 1'b0;
      bit_wr_en <= 1'b0;
      shift_clr <= 1'b0;
      main_done <= 1'b0;
      scan_done <= 1'b0;
      div_err <= 1'b0;
      run_q <= run_cmd;
      // a fresh run command lifts the halt
      if (run_cmd & ~run_q) begin
        halted <= 1'b0;
      end
      if (busy == ST_BLOCK) begin
        // one element pair per cycle, data for elem_idx taken now
        wr_offset <= elem_idx;
        bit_wr_offset <= elem_idx;
        if (blk_cmp) begin
          bit_wr_en <= 1'b1;
          bit_wr_val <= rel_ok(blk_rel, kw, lw);
        end else begin
          wr_en <= 1'b1;
          wr_words <= `LLEU_WORDS_ONE;
          wr_data <= {48'h0, blk_sub ? bk_dif[15:0] : bk_sum[15:0]};
        end
        elem_idx <= elem_idx + 1'b1;
        blk_left <= blk_left - 1'b1;
        if (blk_left == {{(CNT_W-1){1'b0}}, 1'b1}) begin
          busy <= ST_IDLE;
        end
      end else if (take) begin
        case (instr_op)
          `LLEU_OP_CONTACT: begin
            result <= combine(instr_mode, result, cval);
            if (instr_mode == `LLEU_MODE_LOAD) begin
              blk_stk <= {blk_stk[STACK_DEPTH-2:0], result};
            end
          end
          `LLEU_OP_CMP: begin
            result <= combine(instr_mode, result, rel_ok(instr_rel, c1, c2));
            if (instr_mode == `LLEU_MODE_LOAD) begin
              blk_stk <= {blk_stk[STACK_DEPTH-2:0], result};
            end
          end
          `LLEU_OP_ANB: begin
            result <= blk_stk[0] & result;
            blk_stk <= {1'b0, blk_stk[STACK_DEPTH-1:1]};
          end
          `LLEU_OP_ORB: begin
            result <= blk_stk[0] | result;
            blk_stk <= {1'b0, blk_stk[STACK_DEPTH-1:1]};
          end
          `LLEU_OP_PUSH: res_stk <= {res_stk[STACK_DEPTH-2:0], result};
          `LLEU_OP_PEEK: result <= res_stk[0];
          `LLEU_OP_POP: begin
            result <= res_stk[0];
            res_stk <= {1'b0, res_stk[STACK_DEPTH-1:1]};
          end
          `LLEU_OP_NEG: result <= ~result;
          `LLEU_OP_RPULSE, `LLEU_OP_REDGE: begin
            result <= result & ~edge_old;
            edge_mem[edge_idx] <= result;
          end
          `LLEU_OP_FPULSE, `LLEU_OP_FEDGE: begin
            result <= ~result & edge_old;
            edge_mem[edge_idx] <= result;
          end
          `LLEU_OP_OUT: begin
            bit_wr_en <= 1'b1;
            bit_wr_val <= result;
            bit_wr_offset <= {CNT_W{1'b0}};
          end
          `LLEU_OP_SET, `LLEU_OP_RST: begin
            bit_wr_en <= result;
            bit_wr_val <= (instr_op == `LLEU_OP_SET);
            bit_wr_offset <= {CNT_W{1'b0}};
          end
          `LLEU_OP_PLS, `LLEU_OP_PLF: begin
            // written every scan so the device drops after one scan
            bit_wr_en <= 1'b1;
            bit_wr_val <= (instr_op == `LLEU_OP_PLS) ? (result & ~edge_old) :
              (~result & edge_old);
            bit_wr_offset <= {CNT_W{1'b0}};
            edge_mem[edge_idx] <= result;
          end
          `LLEU_OP_SFT: begin
            if (exec) begin
              bit_wr_en <= 1'b1;
              bit_wr_val <= bit_in;
              bit_wr_offset <= {CNT_W{1'b0}};
              shift_clr <= 1'b1;
            end
            if (instr_pulse) begin
              edge_mem[edge_idx] <= result;
            end
          end
          `LLEU_OP_MAIN_PROGRAM_FINISH: main_done <= 1'b1;
          `LLEU_OP_END: scan_done <= 1'b1;
          `LLEU_OP_STOP: begin
            if (result) begin
              halted <= 1'b1;
            end
          end
          default: begin
            // arithmetic and block operations
            if (instr_pulse) begin
              edge_mem[edge_idx] <= result;
            end
            if (exec && is_arith) begin
              if (is_div && div_zero) begin
                div_err <= 1'b1;
              end else begin
                wr_en <= 1'b1;
                wr_data <= next_wr_data;
                wr_words <= next_wr_words;
                wr_offset <= {CNT_W{1'b0}};
              end
            end
            if (exec && is_blk && (blk_count != {CNT_W{1'b0}})) begin
              busy <= ST_BLOCK;
              elem_idx <= {CNT_W{1'b0}};
              blk_left <= blk_count;
              blk_sub <= (instr_op == `LLEU_OP_BKSUB);
              blk_cmp <= (instr_op == `LLEU_OP_BLOCK_WORD_COMPARE);
              blk_rel <= instr_rel;
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/lleu_exec_unit_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "lleu_map.vh"
// ----------------------------------------------------------------
// port checker for the execution unit
// ----------------------------------------------------------------
module lleu_exec_unit_chk #(
  parameter CNT_W = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire logic [4:0] instr_op,
  input wire logic instr_pulse,
  input wire logic instr_wide,
  input wire logic instr_three,
  input wire logic [CNT_W-1:0] blk_count,
  input wire logic [31:0] src2,
  input wire logic run_cmd,
  input wire logic result,
  input wire logic busy,
  input wire logic halted,
  input wire logic [CNT_W-1:0] elem_idx,
  input wire logic wr_en,
  input wire logic [CNT_W-1:0] wr_offset,
  input wire logic bit_wr_en,
  input wire logic main_done,
  input wire logic scan_done,
  input wire logic div_err
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // an instruction is only taken while idle and running
  sequence s_take(logic [4:0] o);
    instr_valid && !busy && !halted && instr_op == o;
  endsequence
  sequence s_div_zero;
    s_take(`LLEU_OP_DIV) ##0 (result && instr_three && !instr_pulse &&
      (instr_wide ? src2 == 32'h0 : src2[15:0] == 16'h0));
  endsequence
  sequence s_block3;
    s_take(`LLEU_OP_BKADD) ##0 (result && !instr_pulse && blk_count == 3);
  endsequence
  chk_div_refuse: assert property (s_div_zero |=> div_err && !wr_en)
    else $error("divide by zero wrote data");
  chk_stop_halts: assert property (s_take(`LLEU_OP_STOP) ##0 result |=> halted)
    else $error("halt not entered");
  chk_halt_holds: assert property (halted && !run_cmd |=> halted)
    else $error("halt left without run");
  chk_halt_quiet: assert property (halted |=> !wr_en && !bit_wr_en)
    else $error("write while halted");
  chk_main_program_finish_done: assert property (s_take(`LLEU_OP_MAIN_PROGRAM_FINISH) |=> main_done && !scan_done)
    else $error("main finish pulse wrong");
  chk_end_done: assert property (s_take(`LLEU_OP_END) |=> scan_done && !main_done)
    else $error("scan end pulse wrong");
  chk_block_write: assert property ($past(busy) |-> wr_en || bit_wr_en)
    else $error("block element without write");
  chk_elem_step: assert property (busy && $past(busy) |-> elem_idx == $past(elem_idx) + 1)
    else $error("element index did not step");
  chk_block_offset: assert property ($past(busy) && wr_en |-> wr_offset == $past(elem_idx))
    else $error("block write offset wrong");
  chk_block_len: assert property (s_block3 |=> busy [*3] ##1 !busy)
    else $error("block length wrong");
endmodule
bind lleu_exec_unit lleu_exec_unit_chk #(.CNT_W(CNT_W)) u_chk (.clk(clk), .rstn(rstn),
  .instr_valid(instr_valid), .instr_op(instr_op), .instr_pulse(instr_pulse),
  .instr_three(instr_three),
  .instr_wide(instr_wide), .blk_count(blk_count), .src2(src2), .run_cmd(run_cmd),
  .result(result), .busy(busy), .halted(halted), .elem_idx(elem_idx), .wr_en(wr_en),
  .wr_offset(wr_offset), .bit_wr_en(bit_wr_en), .main_done(main_done),
  .scan_done(scan_done), .div_err(div_err));
`default_nettype wire

// >>> tb/tb_ladder_logic_execution_unit.sv
`timescale 1ns/10ps
`default_nettype none
`include "lleu_map.vh"
module tb_ladder_logic_execution_unit;
  logic clk = 1'b0, rstn = 1'b0, instr_valid = 1'b0, instr_wide = 1'b0;
  logic instr_three = 1'b0, instr_pulse = 1'b0, bit_in = 1'b0, bit_prev = 1'b0;
  logic run_cmd = 1'b0;
  logic [4:0] instr_op = 5'h00;
  logic [1:0] instr_mode = 2'h0, instr_kind = 2'h0, mm;
  logic [2:0] instr_rel = 3'h0;
  logic [3:0] edge_idx = 4'h0, ei = 4'h0;
  logic [15:0] blk_count = 16'h0003, seed = 16'h74A3;
  logic [31:0] src1 = 32'h0, src2 = 32'h0, dst_in = 32'h0, a, c, d, x, y;
  logic [63:0] v, mk;
  logic [15:0] ea[4], eb[4];
  wire result, busy, halted, wr_en, bit_wr_en, bit_wr_val, shift_clr;
  wire main_done, scan_done, div_err;
  wire [15:0] elem_idx, wr_offset, bit_wr_offset;
  wire [63:0] wr_data;
  wire [2:0] wr_words;
  integer errors = 0, n_compared = 0, i, j, k, sx, sy;
  bit mr, b, kv;
  bit bq[$], rs[$];
  logic [4:0] po[7] = '{`LLEU_OP_ADD, `LLEU_OP_PLS, `LLEU_OP_PLF, `LLEU_OP_RPULSE,
    `LLEU_OP_FPULSE, `LLEU_OP_REDGE, `LLEU_OP_FEDGE};
  logic [4:0] bo[6] = '{`LLEU_OP_BADD, `LLEU_OP_BADD, `LLEU_OP_BSUB, `LLEU_OP_BMUL,
    `LLEU_OP_BDIV, `LLEU_OP_BADD};
  logic [31:0] ba[6] = '{32'h1234, 32'h9999, 32'h1000, 32'h12, 32'h100, 32'h12345678};
  logic [31:0] bb[6] = '{32'h0987, 32'h0002, 32'h0001, 32'h34, 32'h7, 32'h87654322};
  logic [31:0] be[6] = '{32'h2221, 32'h0001, 32'h0999, 32'h0408, 32'h00020014, 32'h0};

  lleu_exec_unit uut (.*);

  // 25 MHz clock
  always #20 clk = ~clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    rnd[31:16] = seed;
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    rnd[15:0] = seed;
  endfunction

  task chk(input string n, input logic [63:0] s, e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // one instruction: fields set on an edge, taken at the next, outputs read after it
  task op(input [4:0] o, input [1:0] m, kd, input [2:0] r, input [3:0] f, input bi,
          input [31:0] p, q, z);
    @(posedge clk);
    instr_op <= o;
    instr_mode <= m;
    instr_kind <= kd;
    instr_rel <= r;
    {instr_wide, instr_three, instr_pulse, bit_prev} <= f;
    bit_in <= bi;
    src1 <= p;
    src2 <= q;
    dst_in <= z;
    edge_idx <= ei;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  task ld(input bit lv);
    op(`LLEU_OP_CONTACT, `LLEU_MODE_LOAD, `LLEU_KIND_LEVEL, 0, 4'h0, lv, 0, 0, 0);
    bq.push_back(mr);
    mr = lv;
  endtask

  task results;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #(40 * 20000);
    errors++;
    results();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    // random contact logic; stack depths kept below the limit so the model stays exact
    for (i = 0; i < 300; i++) begin
      a = rnd();
      case (a[2:0])
        3'h4: if (bq.size() > 0) begin
          b = bq.pop_back();
          mr = a[3] ? (b | mr) : (b & mr);
          op(a[3] ? `LLEU_OP_ORB : `LLEU_OP_ANB, 0, 0, 0, 4'h0, 0, 0, 0, 0);
        end
        3'h5: if (!a[3] && rs.size() < 15) begin
          rs.push_back(mr);
          op(`LLEU_OP_PUSH, 0, 0, 0, 4'h0, 0, 0, 0, 0);
        end else if (a[3] && rs.size() > 0) begin
          mr = rs[$];
          if (a[4]) void'(rs.pop_back());
          op(a[4] ? `LLEU_OP_POP : `LLEU_OP_PEEK, 0, 0, 0, 4'h0, 0, 0, 0, 0);
        end
        3'h6: begin
          mr = !mr;
          op(`LLEU_OP_NEG, 0, 0, 0, 4'h0, 0, 0, 0, 0);
        end
        default: begin
          mm = (a[4:3] == 2'h3 || bq.size() > 14) ? 2'h1 : a[4:3];
          kv = a[6:5] == 0 ? a[7] : a[6:5] == 1 ? !a[7] : a[6:5] == 2 ? a[7] & !a[8] : !a[7] & a[8];
          if (mm == 0) bq.push_back(mr);
          mr = mm == 0 ? kv : mm == 1 ? mr & kv : mr | kv;
          op(`LLEU_OP_CONTACT, mm, a[6:5], 0, {3'h0, a[8]}, a[7], 0, 0, 0);
        end
      endcase
      chk("result", result, mr);
    end
    // comparison contacts, all relations, both widths
    for (i = 0; i < 36; i++) begin
      a = rnd();
      c = i >= 24 ? a : rnd();
      sx = i / 6 % 2 ? $signed(a) : $signed(a[15:0]);
      sy = i / 6 % 2 ? $signed(c) : $signed(c[15:0]);
      j = i % 6;
      kv = j == 0 ? sx == sy : j == 1 ? sx != sy : j == 2 ? sx > sy : j == 3 ? sx <= sy :
           j == 4 ? sx < sy : sx >= sy;
      op(`LLEU_OP_CMP, 0, 0, j, {i / 6 % 2 == 1, 3'h0}, 0, a, c, 0);
      chk("compare", result, kv);
    end
    ld(1);
    // binary add and subtract, in place and three-operand
    for (i = 0; i < 8; i++) begin
      a = rnd();
      c = rnd();
      d = rnd();
      x = i[2] ? a : d;
      y = i[2] ? c : a;
      v = i[0] ? x - y : x + y;
      mk = i[1] ? 64'hFFFFFFFF : 64'hFFFF;
      op(i[0] ? `LLEU_OP_SUB : `LLEU_OP_ADD, 0, 0, 0, {i[1], i[2], 2'h0}, 0, a, c, d);
      chk("sum", wr_data & mk, v & mk);
      chk("sum words", {wr_en, wr_words}, i[1] ? 4'hA : 4'h9);
    end
    // multiply and divide, both widths, then a zero divisor
    for (i = 0; i < 2; i++) begin
      a = rnd() & (i ? 32'h7FFFFFFF : 32'h7FFF);
      c = (rnd() & (i ? 32'hFFFF : 32'hFF)) | 32'h1;
      mk = i ? 64'hFFFFFFFFFFFFFFFF : 64'hFFFFFFFF;
      v = a * c;
      op(`LLEU_OP_MUL, 0, 0, 0, {i[0], 3'h4}, 0, a, c, 0);
      chk("product", wr_data & mk, v);
      chk("product words", wr_words, i ? 4 : 2);
      v = i ? {a % c, a / c} : {a[15:0] % c[15:0], a[15:0] / c[15:0]};
      op(`LLEU_OP_DIV, 0, 0, 0, {i[0], 3'h4}, 0, a, c, 0);
      chk("quotient", wr_data & mk, v & mk);
      op(`LLEU_OP_DIV, 0, 0, 0, {i[0], 3'h4}, 0, a, 0, 0);
      chk("zero divide", {div_err, wr_en}, 2'h2);
    end
    // decimal arithmetic with carries and wrap
    for (i = 0; i < 6; i++) begin
      mk = i == 5 || bo[i] == `LLEU_OP_BMUL || bo[i] == `LLEU_OP_BDIV ? 64'hFFFFFFFF : 64'hFFFF;
      op(bo[i], 0, 0, 0, {i == 5, 3'h4}, 0, ba[i], bb[i], 0);
      chk("decimal", wr_data & mk, be[i]);
    end
    // result false gates data and set, output still writes
    ld(0);
    op(`LLEU_OP_ADD, 0, 0, 0, 4'h4, 0, 1, 1, 0);
    chk("gated add", wr_en, 0);
    op(`LLEU_OP_SET, 0, 0, 0, 4'h0, 0, 0, 0, 0);
    chk("gated set", bit_wr_en, 0);
    op(`LLEU_OP_OUT, 0, 0, 0, 4'h0, 0, 0, 0, 0);
    chk("output", {bit_wr_en, bit_wr_val}, 2'h2);
    ld(1);
    op(`LLEU_OP_RST, 0, 0, 0, 4'h0, 0, 0, 0, 0);
    chk("reset", {bit_wr_en, bit_wr_val}, 2'h2);
    for (i = 0; i < 2; i++) begin
      op(`LLEU_OP_SFT, 0, 0, 0, 4'h0, i[0], 0, 0, 0);
      chk("shift", {shift_clr, bit_wr_en, bit_wr_val}, {2'h3, i[0]});
    end
    // edge-driven forms: one true result per edge of the condition
    for (i = 0; i < 7; i++) begin
      ei = i + 1;
      for (k = 0; k < 3; k++) begin
        ld(i == 2 || i == 4 || i == 6 ? k == 0 : k != 0);
        op(po[i], 0, 0, 0, {2'h0, i == 0, 1'b0}, 0, 1, 1, 1);
        b = i == 0 ? wr_en : (i < 3 ? bit_wr_val : result);
        chk("edge form", b, k == 1);
      end
    end
    // block operations, one element per cycle after the take
    ld(1);
    for (i = 0; i < 3; i++) begin
      for (k = 0; k < 4; k++) begin
        ea[k] = rnd();
        eb[k] = rnd();
      end
      op(`LLEU_OP_BLOCK_WORD_COMPARE + i, 0, 0, `LLEU_REL_GT, 4'h0, 0, ea[0], eb[0], 0);
      chk("busy", busy, 1);
      for (k = 0; k < 3; k++) begin
        @(posedge clk);
        src1 <= ea[(k + 1) % 4];
        src2 <= eb[(k + 1) % 4];
        #1;
        if (i == 0) begin
          chk("block compare", {bit_wr_en, bit_wr_val, bit_wr_offset},
              {1'b1, $signed(ea[k]) > $signed(eb[k]), k[15:0]});
        end else begin
          x = i == 2 ? ea[k] - eb[k] : ea[k] + eb[k];
          chk("block sum", {wr_en, wr_data[15:0], wr_offset}, {1'b1, x[15:0], k[15:0]});
        end
        chk("busy", busy, k < 2);
      end
    end
    // finish, end and halt
    op(`LLEU_OP_MAIN_PROGRAM_FINISH, 0, 0, 0, 4'h0, 0, 0, 0, 0);
    chk("main finish", main_done, 1);
    op(`LLEU_OP_END, 0, 0, 0, 4'h0, 0, 0, 0, 0);
    chk("scan end", scan_done, 1);
    ld(0);
    op(`LLEU_OP_STOP, 0, 0, 0, 4'h0, 0, 0, 0, 0);
    chk("halt false", halted, 0);
    ld(1);
    op(`LLEU_OP_STOP, 0, 0, 0, 4'h0, 0, 0, 0, 0);
    chk("halt", halted, 1);
    op(`LLEU_OP_ADD, 0, 0, 0, 4'h4, 0, 1, 1, 0);
    chk("halted add", {halted, wr_en}, 2'h2);
    @(posedge clk);
    run_cmd <= 1'b1;
    repeat (3) @(posedge clk);
    run_cmd <= 1'b0;
    #1;
    chk("resume", halted, 0);
    results();
  end
endmodule
`default_nettype wire
